/* bench/dcpc_link_model.sv */
`timescale 1ns/1ps
// ********************************************************************
// far side of the control transfer: setup and data packets
// ********************************************************************
module dcpc_link_model (
    input  wire logic        clk,
    output logic             setup_rx_strobe,
    output logic [15:0]      setup_rx_length,
    output logic             rx_pkt_end,
    output logic [15:0]      rx_pkt_bytes,
    output logic             rx_ok
);
    initial begin
        setup_rx_strobe = 1'b0;
        setup_rx_length = 16'h0000;
        rx_pkt_end      = 1'b0;
        rx_pkt_bytes    = 16'h0000;
        rx_ok           = 1'b0;
    end

    // released fields show the inverse, so a stale value never passes
    task setup(input logic [15:0] len);
        @(posedge clk);
        setup_rx_strobe <= 1'b1;
        setup_rx_length <= len;
        @(posedge clk);
        setup_rx_strobe <= 1'b0;
        setup_rx_length <= ~len;
    endtask

    task packet(input logic [15:0] n);
        @(posedge clk);
        rx_pkt_end   <= 1'b1;
        rx_pkt_bytes <= n;
        rx_ok        <= 1'b1;
        @(posedge clk);
        rx_pkt_end   <= 1'b0;
        rx_pkt_bytes <= ~n;
        rx_ok        <= 1'b0;
    endtask
endmodule

/* bench/test_dcpc_top.sv */
`timescale 1ns/1ps
module test_dcpc_top;
    logic        clk;
    logic        resetn;
    logic        ce;
    logic [7:0]  addr;
    logic        rd;
    logic        wr;
    logic [3:0]  be;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        waitreq;
    logic        su_stb;
    logic [15:0] su_len;
    logic        send_req;
    logic [6:0]  max_pkt;
    logic        aclr;
    logic        pkt_end;
    logic [15:0] pkt_bytes;
    logic        pkt_ok;
    logic        sw_byte;
    logic        buffer_valid;
    logic        drained;
    logic        host_pin;
    logic [15:0] setup_length;
    logic        xmit;
    logic        buf_ready;
    logic        nak_set;
    logic        nak_at_end;
    logic [31:0] q;
    logic [32:0] rows [0:4];
    int          num_errors;
    int          cmp_count;

    dcpc_top dut (
        .CLK(clk), .RESETN(resetn), .CE(ce), .AVS_ADDRESS(addr),
        .AVS_READ(rd), .AVS_WRITE(wr), .AVS_BYTEENABLE(be),
        .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata),
        .AVS_WAITREQUEST(waitreq), .SETUP_RX_STROBE(su_stb),
        .SETUP_RX_LENGTH(su_len), .SETUP_SEND_REQUEST(send_req),
        .MAX_PACKET(max_pkt), .AUTO_BUFFER_CLEAR(aclr),
        .RX_PKT_END(pkt_end), .RX_PKT_BYTES(pkt_bytes), .RX_OK(pkt_ok),
        .SW_WR_BYTE(sw_byte), .BUFFER_VALID(buffer_valid), .DRAINED(drained),
        .HOST_ROLE_PIN(host_pin), .SETUP_LENGTH(setup_length),
        .XMIT_DIR(xmit), .BUF_READY(buf_ready), .PIPE_NAK_SET(nak_set)
    );

    dcpc_link_model link (
        .clk(clk), .setup_rx_strobe(su_stb), .setup_rx_length(su_len),
        .rx_pkt_end(pkt_end), .rx_pkt_bytes(pkt_bytes), .rx_ok(pkt_ok)
    );

    always #12.5 clk = ~clk;
    always @(negedge clk) if (pkt_end) nak_at_end = nak_set;

    // ****************************************************************
    // compares, bus cycles and strobes
    // ****************************************************************
    task cmp_word(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task cmp_bit(input logic got, input logic exp);
        cmp_word({31'h0, got}, {31'h0, exp});
    endtask

    task bus(input logic w, input logic [7:0] a, input logic [31:0] d,
             input logic [3:0] b);
        int n;
        @(posedge clk);
        addr  <= a;
        wr    <= w;
        rd    <= ~w;
        wdata <= d;
        be    <= b;
        n = 0;
        @(posedge clk);
        while (waitreq !== 1'b0 && n < 20) begin
            @(posedge clk);
            n++;
        end
        if (n == 20) num_errors++;
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task wreg(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'h3);
    endtask

    task rreg(input logic [7:0] a);
        bus(1'b0, a, 32'h0000_0000, 4'h3);
    endtask

    // which: 0 byte written, 1 buffer valid, 2 drained, 3 buffer clear
    task strobe(input int which, input int n);
        repeat (n) begin
            @(posedge clk);
            case (which)
                0: sw_byte <= 1'b1;
                1: buffer_valid <= 1'b1;
                2: drained <= 1'b1;
                default: aclr <= 1'b1;
            endcase
        end
        @(posedge clk);
        sw_byte <= 1'b0;
        buffer_valid    <= 1'b0;
        drained <= 1'b0;
        aclr    <= 1'b0;
    endtask

    task cfg(input logic [15:0] v);
        strobe(3, 1);
        rreg(dcpc_pkg::OFS_STATUS);
        cmp_bit(q[dcpc_pkg::BIT_RDREADY], 1'b0);
        wreg(dcpc_pkg::OFS_CONFIG, {16'h0000, v});
    endtask

    task expect_ready(input logic exp);
        @(negedge clk);
        cmp_bit(buf_ready, exp);
    endtask

    task tally_and_finish;
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        tally_and_finish;
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        clk = 1'b0;
        resetn = 1'b0;
        ce = 1'b1;
        addr = 8'h00;
        rd = 1'b0;
        wr = 1'b0;
        be = 4'h0;
        wdata = 32'h0000_0000;
        send_req = 1'b0;
        aclr = 1'b0;
        sw_byte = 1'b0;
        buffer_valid = 1'b0;
        drained = 1'b0;
        max_pkt = 7'h08;
        host_pin = 1'b1;
        nak_at_end = 1'b0;
        num_errors = 0;
        cmp_count = 0;
        rows[0] = {16'hffff, 16'h0190, 1'b1};
        rows[1] = {16'h0000, 16'h0000, 1'b0};
        rows[2] = {16'h0010, 16'h0010, 1'b1};
        rows[3] = {16'h0180, 16'h0180, 1'b0};
        rows[4] = {16'hfe6f, 16'h0000, 1'b0};
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        repeat (6) @(posedge clk);
        for (int i = 0; i < 5; i++) begin
            wreg(dcpc_pkg::OFS_CONFIG, {16'h0000, rows[i][32:17]});
            rreg(dcpc_pkg::OFS_CONFIG);
            cmp_word(q, {16'h0000, rows[i][16:1]});
            cmp_bit(xmit, rows[i][0]);
        end
        $display("test config rows done");
        wreg(dcpc_pkg::OFS_LENGTH, 32'h0000_1234);
        send_req <= 1'b1;
        rreg(dcpc_pkg::OFS_STATUS);
        cmp_bit(q[dcpc_pkg::BIT_SENDREQ], 1'b1);
        send_req <= 1'b0;
        rreg(dcpc_pkg::OFS_STATUS);
        cmp_bit(q[dcpc_pkg::BIT_SENDREQ], 1'b0);
        bus(1'b1, dcpc_pkg::OFS_LENGTH, 32'h0000_00cd, 4'h1);
        rreg(dcpc_pkg::OFS_LENGTH);
        cmp_word(q, 32'h0000_12cd);
        cmp_word({16'h0000, setup_length}, 32'h0000_12cd);
        $display("test host length done");
        @(posedge clk);
        resetn <= 1'b0;
        host_pin <= 1'b0;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        rreg(dcpc_pkg::OFS_LENGTH);
        cmp_word(q, {16'h0000, dcpc_pkg::RST_LENGTH});
        rreg(dcpc_pkg::OFS_CONFIG);
        cmp_word(q, {16'h0000, dcpc_pkg::RST_CONFIG});
        wreg(8'h70, 32'hffff_ffff);
        rreg(8'h70);
        cmp_word(q, 32'h0000_0000);
        $display("test reset and unmapped done");
        repeat (6) @(posedge clk);
        link.setup(16'h0040);
        wreg(dcpc_pkg::OFS_LENGTH, 32'h0000_ffff);
        rreg(dcpc_pkg::OFS_LENGTH);
        cmp_word(q, 32'h0000_0040);
        cmp_word({16'h0000, setup_length}, 32'h0000_0040);
        wreg(dcpc_pkg::OFS_CONFIG, 32'h0000_0000);
        wreg(dcpc_pkg::OFS_ROLE, 32'h0000_0002);
        cmp_bit(xmit, 1'b1);
        wreg(dcpc_pkg::OFS_ROLE, 32'h0000_0000);
        cmp_bit(xmit, 1'b0);
        $display("test peripheral role done");
        host_pin <= 1'b1;
        repeat (6) @(posedge clk);
        cfg(16'h0000);
        ce <= 1'b0;
        link.packet(16'h0008);
        expect_ready(1'b0);
        @(posedge clk);
        ce <= 1'b1;
        link.packet(16'h0008);
        expect_ready(1'b1);
        strobe(2, 1);
        expect_ready(1'b0);
        cfg(16'h0010);
        strobe(0, 7);
        expect_ready(1'b0);
        strobe(0, 1);
        expect_ready(1'b1);
        strobe(2, 1);
        strobe(0, 3);
        expect_ready(1'b0);
        strobe(1, 1);
        expect_ready(1'b1);
        strobe(2, 1);
        $display("test single mode done");
        max_pkt <= 7'h40;
        cfg(16'h0100);
        repeat (3) link.packet(16'h0040);
        expect_ready(1'b0);
        link.packet(16'h0040);
        expect_ready(1'b1);
        strobe(2, 1);
        link.packet(16'h0000);
        expect_ready(1'b0);
        link.packet(16'h000a);
        expect_ready(1'b1);
        strobe(2, 1);
        link.packet(16'h0040);
        link.packet(16'h0000);
        expect_ready(1'b1);
        strobe(2, 1);
        cfg(16'h0110);
        strobe(0, 255);
        expect_ready(1'b0);
        strobe(0, 1);
        expect_ready(1'b1);
        strobe(2, 1);
        strobe(1, 1);
        expect_ready(1'b1);
        strobe(2, 1);
        $display("test continuous mode done");
        cfg(16'h0080);
        link.packet(16'h0040);
        cmp_bit(nak_at_end, 1'b0);
        strobe(2, 1);
        link.packet(16'h0000);
        cmp_bit(nak_at_end, 1'b1);
        strobe(2, 1);
        link.packet(16'h0005);
        cmp_bit(nak_at_end, 1'b1);
        rreg(dcpc_pkg::OFS_STATUS);
        cmp_bit(q[dcpc_pkg::BIT_NAK], 1'b1);
        strobe(2, 1);
        cfg(16'h0000);
        link.packet(16'h0005);
        cmp_bit(nak_at_end, 1'b0);
        $display("test end disable done");
        tally_and_finish;
    end
endmodule

/* include/dcpc_cfg_if.sv */
`timescale 1ns/1ps
interface dcpc_cfg_if;
    logic        cnt_mode;
    logic        eot_disable;
    logic        xmit;
    logic        buf_ready;
    logic        set_nak;
    logic [15:0] fill_count;

    modport ctl (output cnt_mode, output eot_disable, output xmit,
                 input buf_ready, input set_nak, input fill_count);
    modport buf_side (input cnt_mode, input eot_disable, input xmit,
                      output buf_ready, output set_nak,
                      output fill_count);
endinterface

/* include/dcpc_pkg.sv */
package dcpc_pkg;
    // ****************************************************************
    // register offsets (byte addresses on the avalon word bus)
    // ****************************************************************
    localparam logic [7:0] OFS_LENGTH = 8'h58;
    localparam logic [7:0] OFS_CONFIG = 8'h5c;
    localparam logic [7:0] OFS_ROLE   = 8'h60;
    localparam logic [7:0] OFS_STATUS = 8'h64;

    // ****************************************************************
    // control_pipe_config fields
    // ****************************************************************
    localparam int BIT_CNTMODE = 8;
    localparam int BIT_EOTDIS  = 7;
    localparam int BIT_DIR     = 4;

    // role register and status register fields
    localparam int BIT_HOST    = 0;
    localparam int BIT_INSEL   = 1;
    localparam int BIT_RDREADY = 0;
    localparam int BIT_TXREADY = 1;
    localparam int BIT_NAK     = 2;
    localparam int BIT_XMIT    = 3;
    localparam int BIT_SENDREQ = 4;

    localparam logic [15:0] RST_LENGTH = 16'h0000;
    localparam logic [15:0] RST_CONFIG = 16'h0000;
    localparam logic [15:0] CFG_MASK   = 16'h0190;

    // one buffer side of the default control pipe, in bytes
    localparam int SIDE_BYTES = 256;

    typedef enum logic [1:0] {
        DCPC_IDLE  = 2'b00,
        DCPC_FILL  = 2'b01,
        DCPC_READY = 2'b10
    } dcpc_buf_state_t;
endpackage

/* logic/dcpc_buf_ctl.sv */
`timescale 1ns/1ps
module dcpc_buf_ctl #(
    parameter int SIDE = dcpc_pkg::SIDE_BYTES
) (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        ce,
    dcpc_cfg_if.buf_side     cfg,
    input  wire logic [6:0]  max_packet,
    input  wire logic        buf_clear,
    input  wire logic        rx_pkt_end,
    input  wire logic [15:0] rx_pkt_bytes,
    input  wire logic        rx_ok,
    input  wire logic        sw_wr_byte,
    input  wire logic        sw_valid,
    input  wire logic        drained
);
    dcpc_pkg::dcpc_buf_state_t state;
    dcpc_pkg::dcpc_buf_state_t next_state;
    logic [15:0] count;
    logic [15:0] next_count;
    logic        short_pkt;
    logic        rx_done;
    logic        tx_done;
    logic [15:0] side_w;
    logic [15:0] mps_w;

    assign side_w    = 16'(SIDE);
    assign mps_w     = {9'h000, max_packet};
    assign short_pkt = rx_pkt_bytes < mps_w;

    // receive side completion
    assign rx_done = rx_pkt_end && rx_ok && (
        !cfg.cnt_mode ||
        (count + rx_pkt_bytes >= side_w) ||
        (short_pkt && rx_pkt_bytes != 16'h0000) ||
        (rx_pkt_bytes == 16'h0000 && count != 16'h0000));

    // transmit side completion, count includes the byte written now
    assign tx_done = (sw_wr_byte && !cfg.cnt_mode
                      && count + 16'h0001 == mps_w) ||
                     (sw_wr_byte && cfg.cnt_mode
                      && count + 16'h0001 == side_w) ||
                     (sw_valid && count < (cfg.cnt_mode ? side_w
                                                        : mps_w));

    assign next_count = buf_clear ? 16'h0000 :
                        (state == dcpc_pkg::DCPC_READY) ?
                            (drained ? 16'h0000 : count) :
                        (!cfg.xmit && rx_pkt_end && rx_ok) ?
                            count + rx_pkt_bytes :
                        (cfg.xmit && sw_wr_byte) ? count + 16'h0001 :
                        count;

    always_comb begin
        next_state = state;
        case (state)
            dcpc_pkg::DCPC_IDLE,
            dcpc_pkg::DCPC_FILL: begin
                if (cfg.xmit ? tx_done : rx_done) begin
                    next_state = dcpc_pkg::DCPC_READY;
                end else if (next_count != 16'h0000) begin
                    next_state = dcpc_pkg::DCPC_FILL;
                end
            end
            dcpc_pkg::DCPC_READY: begin
                if (drained) begin
                    next_state = dcpc_pkg::DCPC_IDLE;
                end
            end
            default: next_state = dcpc_pkg::DCPC_IDLE;
        endcase
        if (buf_clear) begin
            next_state = dcpc_pkg::DCPC_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state <= dcpc_pkg::DCPC_IDLE;
            count <= 16'h0000;
        end else if (ce) begin
            state <= next_state;
            count <= next_count;
        end
    end

    assign cfg.buf_ready  = state == dcpc_pkg::DCPC_READY;
    assign cfg.fill_count = count;
    // short packet, or zero-length packet unless the continuous side is empty, normally ends the transfer
    assign cfg.set_nak = ce && cfg.eot_disable && !cfg.xmit && rx_pkt_end
                         && rx_ok && short_pkt;

    a_rx_single_pkt : assert property (
        @(posedge clk) disable iff (!resetn)
        ce && !cfg.cnt_mode && !cfg.xmit && rx_pkt_end && rx_ok && !buf_clear
        && state != dcpc_pkg::DCPC_READY |=> cfg.buf_ready)
        else $error("packet received but buffer not readable");
    a_tx_valid_ready : assert property (
        @(posedge clk) disable iff (!resetn)
        ce && cfg.xmit && sw_valid && !buf_clear
        && state != dcpc_pkg::DCPC_READY |=> cfg.buf_ready)
        else $error("buffer valid did not ready the buffer");
    a_cnt_full_side : assert property (
        @(posedge clk) disable iff (!resetn)
        ce && cfg.cnt_mode && cfg.xmit && sw_wr_byte && !buf_clear
        && state != dcpc_pkg::DCPC_READY && count == side_w - 16'h0001
        |=> cfg.buf_ready)
        else $error("full side written but buffer not ready");
    a_cnt_zlp_empty : assert property (
        @(posedge clk) disable iff (!resetn)
        ce && cfg.cnt_mode && !cfg.xmit && rx_pkt_end && rx_ok
        && rx_pkt_bytes == 16'h0000 && count == 16'h0000
        && state == dcpc_pkg::DCPC_IDLE && !buf_clear
        |=> !cfg.buf_ready)
        else $error("empty zero-length packet made buffer readable");
    a_clear_empties : assert property (@(posedge clk) disable iff (!resetn)
        ce && buf_clear |=> count == 16'h0000 && !cfg.buf_ready)
        else $error("buffer clear did not empty the buffer");
    c_rx_ready : cover property (@(posedge clk) disable iff (!resetn)
        !cfg.xmit && cfg.buf_ready);
    c_tx_ready : cover property (@(posedge clk) disable iff (!resetn)
        cfg.xmit && cfg.cnt_mode && cfg.buf_ready);
endmodule

/* logic/dcpc_sync.sv */
`timescale 1ns/1ps
module dcpc_sync (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic ce,
    input  wire logic async_in,
    output logic      sync_out
);
    logic s1;
    logic s2;
    logic s3;

    // a change is taken once the second and third stages agree
    always_ff @(posedge clk) begin
        if (!resetn) begin
            s1       <= 1'b0;
            s2       <= 1'b0;
            s3       <= 1'b0;
            sync_out <= 1'b0;
        end else if (ce) begin
            s1 <= async_in;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                sync_out <= s3;
            end
        end
    end
endmodule

/* logic/dcpc_top.sv */
`timescale 1ns/1ps
// Functional notes
// - length field sixteen bits, low byte b7-0
// - peripheral: received length loaded, writes ignored
// - host: direction bit, zero receive, one send
// - peripheral: in-select bit gives direction instead
// - single mode receive: readable after one packet
// - single mode send: full packet or valid
// - continuous receive: side full, short, zlp after data
// - continuous send: side full or valid
// - end disable sets nak on a short receive packet
// - short packet, or zero-length packet unless continuous side empty, ends transfer
module dcpc_top #(
    parameter int SIDE = dcpc_pkg::SIDE_BYTES
) (
    input  wire logic        CLK,
    input  wire logic        RESETN,
    input  wire logic        CE,
    // avalon-mm slave
    input  wire logic [7:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    input  wire logic [31:0] AVS_WRITEDATA,
    output logic [31:0]      AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    // setup receive path (peripheral role)
    input  wire logic        SETUP_RX_STROBE,
    input  wire logic [15:0] SETUP_RX_LENGTH,
    // setup send request state from the pipe control logic
    input  wire logic        SETUP_SEND_REQUEST,
    // packet and buffer events from the link engine
    input  wire logic [6:0]  MAX_PACKET,
    input  wire logic        AUTO_BUFFER_CLEAR,
    input  wire logic        RX_PKT_END,
    input  wire logic [15:0] RX_PKT_BYTES,
    input  wire logic        RX_OK,
    input  wire logic        SW_WR_BYTE,
    input  wire logic        BUFFER_VALID,
    input  wire logic        DRAINED,
    // role strap pin, from outside the clock domain
    input  wire logic        HOST_ROLE_PIN,
    output logic [15:0]      SETUP_LENGTH,
    output logic             XMIT_DIR,
    output logic             BUF_READY,
    output logic             PIPE_NAK_SET
);
    // ****************************************************************
    // state and wiring
    // ****************************************************************
    logic [15:0] length;
    logic [15:0] config_reg;
    logic        in_select;
    logic        host_sync;
    logic        nak_seen;
    logic        pending;
    logic [31:0] rdata;
    logic [31:0] next_rdata;

    dcpc_cfg_if cfg ();

    dcpc_sync u_sync (
        .clk      (CLK),
        .resetn   (RESETN),
        .ce       (CE),
        .async_in (HOST_ROLE_PIN),
        .sync_out (host_sync)
    );

    dcpc_buf_ctl #(
        .SIDE (SIDE)
    ) u_buf (
        .clk          (CLK),
        .resetn       (RESETN),
        .ce           (CE),
        .cfg          (cfg),
        .max_packet   (MAX_PACKET),
        .buf_clear    (AUTO_BUFFER_CLEAR),
        .rx_pkt_end   (RX_PKT_END),
        .rx_pkt_bytes (RX_PKT_BYTES),
        .rx_ok        (RX_OK),
        .sw_wr_byte   (SW_WR_BYTE),
        .sw_valid     (BUFFER_VALID),
        .drained      (DRAINED)
    );

    // ****************************************************************
    // address decode
    // ****************************************************************
    logic hit_len;
    logic hit_cfg;
    logic hit_role;
    logic hit_stat;
    logic wr_len;
    logic wr_cfg;
    logic wr_role;
    logic [15:0] wmask;
    logic [15:0] len_wdata;
    logic [15:0] cfg_wdata;

    assign hit_len  = AVS_ADDRESS == dcpc_pkg::OFS_LENGTH;
    assign hit_cfg  = AVS_ADDRESS == dcpc_pkg::OFS_CONFIG;
    assign hit_role = AVS_ADDRESS == dcpc_pkg::OFS_ROLE;
    assign hit_stat = AVS_ADDRESS == dcpc_pkg::OFS_STATUS;
    assign wmask = {{8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};

    // peripheral role ignores software writes to the length field
    assign wr_len  = CE && AVS_WRITE && !pending && hit_len
                     && host_sync;
    assign wr_cfg  = CE && AVS_WRITE && !pending && hit_cfg;
    assign wr_role = CE && AVS_WRITE && !pending && hit_role;

    // b7-0 is the low byte, selected by byte lane 0
    assign len_wdata = (length & ~wmask)
                       | (AVS_WRITEDATA[15:0] & wmask);
    // unassigned bits are never stored
    assign cfg_wdata = ((config_reg & ~wmask)
                       | (AVS_WRITEDATA[15:0] & wmask))
                       & dcpc_pkg::CFG_MASK;

    // ****************************************************************
    // length field
    // ****************************************************************
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            length <= dcpc_pkg::RST_LENGTH;
        end else if (CE) begin
            if (!host_sync && SETUP_RX_STROBE) begin
                length <= SETUP_RX_LENGTH;
            end else if (wr_len) begin
                length <= len_wdata;
            end
        end
    end

    // ****************************************************************
    // configuration and role registers
    // ****************************************************************
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            config_reg <= dcpc_pkg::RST_CONFIG;
            in_select  <= 1'b0;
        end else if (CE) begin
            if (wr_cfg) begin
                config_reg <= cfg_wdata;
            end
            if (wr_role && AVS_BYTEENABLE[0]) begin
                in_select <= AVS_WRITEDATA[dcpc_pkg::BIT_INSEL];
            end
        end
    end

    // direction source depends on role
    assign cfg.xmit = host_sync
                      ? config_reg[dcpc_pkg::BIT_DIR]
                      : in_select;
    assign cfg.cnt_mode    = config_reg[dcpc_pkg::BIT_CNTMODE];
    // end-of-transfer nak only applies to a receiving pipe
    assign cfg.eot_disable = config_reg[dcpc_pkg::BIT_EOTDIS];

    // sticky view of the nak switch, cleared by a role register write with bit 16 set
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            nak_seen <= 1'b0;
        end else if (CE) begin
            if (cfg.set_nak) begin
                nak_seen <= 1'b1;
            end else if (wr_role && AVS_WRITEDATA[16]) begin
                nak_seen <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // avalon answer: one wait cycle, then data from a register
    // ****************************************************************
    assign next_rdata =
        hit_len  ? {16'h0000, length} :
        hit_cfg  ? {16'h0000, config_reg & dcpc_pkg::CFG_MASK} :
        hit_role ? {30'h0, in_select, host_sync} :
        // pending setup request: software holds off length rewrites
        hit_stat ? {27'h0, SETUP_SEND_REQUEST, cfg.xmit, nak_seen,
                    cfg.buf_ready, cfg.buf_ready} :
        32'h00000000;

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            pending <= 1'b0;
            rdata   <= 32'h00000000;
        end else if (CE) begin
            pending <= (AVS_READ || AVS_WRITE) && !pending;
            if (AVS_READ && !pending) begin
                rdata <= next_rdata;
            end
        end
    end

    assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !pending;
    assign AVS_READDATA    = rdata;
    assign SETUP_LENGTH    = length;
    assign XMIT_DIR        = cfg.xmit;
    assign BUF_READY       = cfg.buf_ready;
    assign PIPE_NAK_SET    = cfg.set_nak;

    // ****************************************************************
    // checks
    // ****************************************************************
    a_len_periph_ro : assert property (
        @(posedge CLK) disable iff (!RESETN)
        CE && !host_sync && !SETUP_RX_STROBE |=> $stable(length))
        else $error("length changed by software in peripheral role");
    a_len_rx_load : assert property (
        @(posedge CLK) disable iff (!RESETN)
        CE && !host_sync && SETUP_RX_STROBE
        |=> length == $past(SETUP_RX_LENGTH))
        else $error("received length not loaded");
    a_len_low_byte : assert property (
        @(posedge CLK) disable iff (!RESETN)
        wr_len && AVS_BYTEENABLE == 4'h1
        |=> length[7:0] == $past(AVS_WRITEDATA[7:0])
            && length[15:8] == $past(length[15:8]))
        else $error("low byte write mismatch");
    a_dir_host : assert property (
        @(posedge CLK) disable iff (!RESETN)
        host_sync |-> XMIT_DIR == config_reg[dcpc_pkg::BIT_DIR])
        else $error("host direction not from direction bit");
    a_dir_periph : assert property (
        @(posedge CLK) disable iff (!RESETN)
        !host_sync |-> XMIT_DIR == in_select)
        else $error("peripheral direction not from in-select");
    a_nak_on_short : assert property (
        @(posedge CLK) disable iff (!RESETN)
        CE && config_reg[dcpc_pkg::BIT_EOTDIS] && !XMIT_DIR && RX_PKT_END
        && RX_OK && RX_PKT_BYTES < {9'h0, MAX_PACKET}
        |-> PIPE_NAK_SET ##1 nak_seen)
        else $error("short packet did not switch pipe to nak");
    a_cfg_unassigned : assert property (
        @(posedge CLK) disable iff (!RESETN)
        (config_reg & ~dcpc_pkg::CFG_MASK) == 16'h0000)
        else $error("unassigned config bit set");
    a_bus_answer : assert property (@(posedge CLK) disable iff (!RESETN)
        CE && AVS_WAITREQUEST |=> !AVS_WAITREQUEST || !CE)
        else $error("bus request waited more than one cycle");
    c_host_len_write : cover property (@(posedge CLK) disable iff (!RESETN)
        wr_len);
    c_periph_load : cover property (@(posedge CLK) disable iff (!RESETN)
        !host_sync && SETUP_RX_STROBE);
    c_nak_set : cover property (@(posedge CLK) disable iff (!RESETN)
        PIPE_NAK_SET);
endmodule
